// ==== verilog/wdog_defs.svh ====
// Constants for the host and process data watchdog block.
// Assumes byte-wide register ports with byte addresses.
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH

// ============================================================
// Register byte offsets
`define WD_OFS_DIV_LO        12'h400
`define WD_OFS_DIV_HI        12'h401
`define WD_OFS_HOST_TIME_LO  12'h410
`define WD_OFS_HOST_TIME_HI  12'h411
`define WD_OFS_PD_TIME_LO    12'h420
`define WD_OFS_PD_TIME_HI    12'h421
`define WD_OFS_PD_STAT_LO    12'h440
`define WD_OFS_PD_STAT_HI    12'h441
`define WD_OFS_PD_CNT        12'h442
`define WD_OFS_HOST_CNT      12'h443

// ============================================================
// Reset values
`define WD_RST_DIV           16'h09C2
`define WD_RST_TIME          16'h03E8
`define WD_RST_CNT           8'h00

// ============================================================
// Field positions and limits
`define WD_STAT_RUN_BIT      0
`define WD_CNT_MAX           8'hFF
`define WD_DIV_EXTRA         17'h0_0001

`endif

// ==== verilog/wdog_pkg.sv ====
// Types shared by the watchdog block files.
// Assumes wdog_defs.svh holds the numeric constants.
package wdog_pkg;
    typedef logic [15:0] wd_word_t;   // 16-bit watchdog register
    typedef logic [7:0]  wd_byte_t;   // One register byte
    typedef logic [11:0] wd_addr_t;   // Byte address
endpackage

// ==== verilog/wdog_timer.sv ====
// One watchdog timer counting basic increments up to its period.
// Assumes a one-cycle increment pulse and a one-cycle restart pulse.
`timescale 1ns/1ps
`default_nettype none
module wdog_timer
    import wdog_pkg::*;
(
    input  wire logic     mclk,      // System clock
    input  wire logic     rst,       // Synchronous reset, high
    input  wire logic     inc,       // Basic increment pulse
    input  wire logic     restart,   // Restart event pulse
    input  wire wd_word_t period,    // Programmed increments, 0 = off
    output logic          expired,   // Expired level
    output logic          fired      // One-cycle expiry pulse
);
    // ============================================================
    // State
    wd_word_t count_q, count_d;   // Elapsed increments
    logic     exp_q, exp_d;       // Expired flag
    logic     fire_q, fire_d;     // Expiry pulse

    // Next state of the countdown
    always_comb begin
        count_d = count_q;
        exp_d   = exp_q;
        fire_d  = 1'b0;
        if (period == 16'h0000) begin
            // Disabled: never expires
            count_d = 16'h0000;
            exp_d   = 1'b0;
        end else if (restart) begin
            // Restart from the full period
            count_d = 16'h0000;
            exp_d   = 1'b0;
        end else if (inc && !exp_q) begin
            if (count_q + 16'h0001 >= period) begin
                // Period used up without restart
                exp_d  = 1'b1;
                fire_d = 1'b1;
            end else begin
                count_d = count_q + 16'h0001;
            end
        end
    end

    // Register the countdown
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_q <= 16'h0000;
            exp_q   <= 1'b0;
            fire_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            exp_q   <= exp_d;
            fire_q  <= fire_d;
        end
    end

    assign expired = exp_q;
    assign fired   = fire_q;

    // ============================================================
    // Checks
    a_fire_sets_exp: assert property (@(posedge mclk) disable iff (rst)
        fire_q |-> exp_q)
        else $error("expiry pulse without expired level");
    a_exp_holds: assert property (@(posedge mclk) disable iff (rst)
        exp_q && !restart && period != 16'h0000 |=> exp_q)
        else $error("expired state dropped without restart");
endmodule
`default_nettype wire

// ==== verilog/wdog_top.sv ====
// Top of the host and process data watchdog block.
// Assumes byte-wide register ports from both sides, synchronous to mclk,
// and a one-cycle base_tick strobe per 25 MHz base clock tick.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defs.svh"
module wdog_top
    import wdog_pkg::*;
#(
    parameter int NCH = 4                          // Buffer channel count
)(
    input  wire logic           mclk,              // 20 MHz clock
    input  wire logic           rst,               // Synchronous reset, high
    input  wire logic           base_tick,         // 25 MHz base tick strobe
    input  wire wd_addr_t       fb_addr,           // Fieldbus byte address
    input  wire logic           fb_wr,             // Fieldbus write strobe
    input  wire logic           fb_rd,             // Fieldbus read strobe
    input  wire wd_byte_t       fb_wdata,          // Fieldbus write byte
    output logic [7:0]          fb_rdata,          // Fieldbus read byte
    input  wire wd_addr_t       host_addr,         // Host byte address
    input  wire logic           host_wr,           // Host write strobe
    input  wire logic           host_rd,           // Host read strobe
    output logic [7:0]          host_rdata,        // Host read byte
    input  wire logic [NCH-1:0] buf_wr,            // Channel write pulses
    input  wire logic [NCH-1:0] buf_trig_en,       // Channel trigger enables
    output logic                link_status_host_wd, // Host watchdog expired
    output logic                app_event_pd       // Process event request bit
);
    // ============================================================
    // Registers
    wd_word_t div_q, div_d;             // Increment divider
    wd_word_t host_time_q, host_time_d; // Host watchdog period
    wd_word_t pd_time_q, pd_time_d;     // Process watchdog period
    wd_byte_t pd_cnt_q, pd_cnt_d;       // Process expiry counter
    wd_byte_t host_cnt_q, host_cnt_d;   // Host expiry counter
    wd_byte_t fb_rd_q, fb_rd_d;         // Fieldbus read data
    wd_byte_t host_rd_q, host_rd_d;     // Host read data
    logic     event_q, event_d;         // Process event request
    logic     hstat_q, hstat_d;         // Host expired status copy
    logic [16:0] presc_q, presc_d;      // Base tick prescaler
    logic     inc_q, inc_d;             // Basic increment pulse

    // Timer outputs and decoded strobes
    logic host_exp, host_fire;          // Host watchdog state
    logic pd_exp, pd_fire;              // Process watchdog state
    logic host_access;                  // Any host access
    logic pd_trigger;                   // Qualifying channel write
    logic cnt_clear;                    // Fieldbus counter write
    logic stat_read;                    // Status register read

    assign host_access = host_wr | host_rd;
    assign pd_trigger  = |(buf_wr & buf_trig_en);
    assign cnt_clear   = fb_wr && (fb_addr == `WD_OFS_PD_CNT ||
                                   fb_addr == `WD_OFS_HOST_CNT);
    assign stat_read   = (fb_rd && (fb_addr == `WD_OFS_PD_STAT_LO ||
                                    fb_addr == `WD_OFS_PD_STAT_HI)) ||
                         (host_rd && (host_addr == `WD_OFS_PD_STAT_LO ||
                                      host_addr == `WD_OFS_PD_STAT_HI));

    // ============================================================
    // Read mux, shared by both sides
    function automatic wd_byte_t read_byte(input wd_addr_t a);
        wd_byte_t r;
        r = 8'h00;
        unique case (a)
            `WD_OFS_DIV_LO:       r = div_q[7:0];
            `WD_OFS_DIV_HI:       r = div_q[15:8];
            `WD_OFS_HOST_TIME_LO: r = host_time_q[7:0];
            `WD_OFS_HOST_TIME_HI: r = host_time_q[15:8];
            `WD_OFS_PD_TIME_LO:   r = pd_time_q[7:0];
            `WD_OFS_PD_TIME_HI:   r = pd_time_q[15:8];
            `WD_OFS_PD_STAT_LO:   r = {7'h00, ~pd_exp};
            `WD_OFS_PD_STAT_HI:   r = 8'h00;
            `WD_OFS_PD_CNT:       r = pd_cnt_q;
            `WD_OFS_HOST_CNT:     r = host_cnt_q;
            default:              r = 8'h00;
        endcase
        return r;
    endfunction

    // ============================================================
    // Prescaler: one increment per divider plus two base ticks
    always_comb begin
        presc_d = presc_q;
        inc_d   = 1'b0;
        if (base_tick) begin
            // At or past the end, so a lowered divider never waits for a wrap
            if (presc_q >= ({1'b0, div_q} + `WD_DIV_EXTRA)) begin
                presc_d = 17'h0_0000;
                inc_d   = 1'b1;
            end else begin
                presc_d = presc_q + 17'h0_0001;
            end
        end
    end

    // Register the prescaler
    always_ff @(posedge mclk) begin
        if (rst) begin
            presc_q <= 17'h0_0000;
            inc_q   <= 1'b0;
        end else begin
            presc_q <= presc_d;
            inc_q   <= inc_d;
        end
    end

    // ============================================================
    // Register file next state
    always_comb begin
        div_d       = div_q;
        host_time_d = host_time_q;
        pd_time_d   = pd_time_q;
        pd_cnt_d    = pd_cnt_q;
        host_cnt_d  = host_cnt_q;
        event_d     = event_q;
        // Only the fieldbus side may change the time registers
        if (fb_wr) begin
            unique case (fb_addr)
                `WD_OFS_DIV_LO:       div_d[7:0]        = fb_wdata;
                `WD_OFS_DIV_HI:       div_d[15:8]       = fb_wdata;
                `WD_OFS_HOST_TIME_LO: host_time_d[7:0]  = fb_wdata;
                `WD_OFS_HOST_TIME_HI: host_time_d[15:8] = fb_wdata;
                `WD_OFS_PD_TIME_LO:   pd_time_d[7:0]    = fb_wdata;
                `WD_OFS_PD_TIME_HI:   pd_time_d[15:8]   = fb_wdata;
                default:              ;
            endcase
        end
        // Clear both counters; a coincident expiry still counts
        if (cnt_clear) begin
            pd_cnt_d   = `WD_RST_CNT;
            host_cnt_d = `WD_RST_CNT;
        end
        if (pd_fire && pd_cnt_d != `WD_CNT_MAX) begin
            pd_cnt_d = pd_cnt_d + 8'h01;
        end
        if (host_fire && host_cnt_d != `WD_CNT_MAX) begin
            host_cnt_d = host_cnt_d + 8'h01;
        end
        // Event request: set wins over read clear
        if (stat_read) begin
            event_d = 1'b0;
        end
        if (pd_fire) begin
            event_d = 1'b1;
        end
    end

    // Read data and status copy
    always_comb begin
        fb_rd_d   = fb_rd ? read_byte(fb_addr) : fb_rd_q;
        host_rd_d = host_rd ? read_byte(host_addr) : host_rd_q;
        hstat_d   = host_exp;
    end

    // Register the register file
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_q       <= `WD_RST_DIV;
            host_time_q <= `WD_RST_TIME;
            pd_time_q   <= `WD_RST_TIME;
            pd_cnt_q    <= `WD_RST_CNT;
            host_cnt_q  <= `WD_RST_CNT;
            event_q     <= 1'b0;
            fb_rd_q     <= 8'h00;
            host_rd_q   <= 8'h00;
            hstat_q     <= 1'b0;
        end else begin
            div_q       <= div_d;
            host_time_q <= host_time_d;
            pd_time_q   <= pd_time_d;
            pd_cnt_q    <= pd_cnt_d;
            host_cnt_q  <= host_cnt_d;
            event_q     <= event_d;
            fb_rd_q     <= fb_rd_d;
            host_rd_q   <= host_rd_d;
            hstat_q     <= hstat_d;
        end
    end

    // ============================================================
    // Watchdog timers
    wdog_timer u_host_wd (
        .mclk    (mclk),
        .rst     (rst),
        .inc     (inc_q),
        .restart (host_access),
        .period  (host_time_q),
        .expired (host_exp),
        .fired   (host_fire)
    );

    wdog_timer u_pd_wd (
        .mclk    (mclk),
        .rst     (rst),
        .inc     (inc_q),
        .restart (pd_trigger),
        .period  (pd_time_q),
        .expired (pd_exp),
        .fired   (pd_fire)
    );

    // Outputs
    assign fb_rdata            = fb_rd_q;
    assign host_rdata          = host_rd_q;
    assign link_status_host_wd = hstat_q;
    assign app_event_pd        = event_q;

    // ============================================================
    // Checks
    a_time_reset: assert property (@(posedge mclk)
        $past(rst) |-> host_time_q == 16'h03E8 && pd_time_q == 16'h03E8)
        else $error("time registers not at reset value");
    a_host_disable: assert property (@(posedge mclk) disable iff (rst)
        host_time_q == 16'h0000 |=> !host_exp)
        else $error("host watchdog expired while disabled");
    a_host_restart: assert property (@(posedge mclk) disable iff (rst)
        host_access |=> !host_exp ##1 !link_status_host_wd)
        else $error("host access did not restart watchdog");
    a_pd_restart: assert property (@(posedge mclk) disable iff (rst)
        pd_trigger |=> !pd_exp)
        else $error("triggered channel write did not restart");
    a_pd_status: assert property (@(posedge mclk) disable iff (rst)
        fb_rd && fb_addr == 12'h440 |=> fb_rdata == {7'h00, ~$past(pd_exp)})
        else $error("process status byte wrong");
    a_event_clear: assert property (@(posedge mclk) disable iff (rst)
        stat_read && !pd_fire |=> !app_event_pd)
        else $error("status read did not clear event");
    a_pd_cnt_sat: assert property (@(posedge mclk) disable iff (rst)
        pd_cnt_q == 8'hFF && !cnt_clear |=> pd_cnt_q == 8'hFF)
        else $error("process counter left saturation");
    a_host_cnt_inc: assert property (@(posedge mclk) disable iff (rst)
        host_fire && !cnt_clear && host_cnt_q != 8'hFF
        |=> host_cnt_q == $past(host_cnt_q) + 8'h01)
        else $error("host counter did not count expiry");
    a_cnt_clear: assert property (@(posedge mclk) disable iff (rst)
        cnt_clear && !pd_fire && !host_fire |=> pd_cnt_q == 8'h00 && host_cnt_q == 8'h00)
        else $error("counters not cleared together");
    a_host_ro: assert property (@(posedge mclk) disable iff (rst)
        host_wr && !fb_wr |=> $stable(host_time_q) && $stable(pd_time_q))
        else $error("host changed a time register");
    a_inc_spacing: assert property (@(posedge mclk) disable iff (rst)
        inc_q |-> !$past(inc_q))
        else $error("increment pulses back to back");

    c_host_expire: cover property (@(posedge mclk) disable iff (rst) host_fire);
    c_pd_expire:   cover property (@(posedge mclk) disable iff (rst) pd_fire);
    c_evt_clear:   cover property (@(posedge mclk) disable iff (rst)
        app_event_pd && stat_read);
    c_cnt_clear:   cover property (@(posedge mclk) disable iff (rst)
        cnt_clear && pd_cnt_q != 8'h00);
endmodule
`default_nettype wire

// ==== bench/wdog_bus_model.sv ====
// Bus model of the fieldbus master and the local host controller.
// Assumes byte strobes are taken on the rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module wdog_bus_model
    import wdog_pkg::*;
(
    input  wire logic     mclk,      // System clock
    output var  wd_addr_t fb_addr,   // Fieldbus byte address
    output logic          fb_wr,     // Fieldbus write strobe
    output logic          fb_rd,     // Fieldbus read strobe
    output var  wd_byte_t fb_wdata,  // Fieldbus write byte
    output var  wd_addr_t host_addr, // Host byte address
    output logic          host_wr,   // Host write strobe
    output logic          host_rd    // Host read strobe
);
    // ============================================================
    // Idle levels
    initial begin
        fb_addr = 12'h000;
        fb_wr = 1'b0;
        fb_rd = 1'b0;
        fb_wdata = 8'h00;
        host_addr = 12'h000;
        host_wr = 1'b0;
        host_rd = 1'b0;
    end

    // One fieldbus byte access; released lines show the inverse
    task automatic fb_access(input wd_addr_t a, input logic wr, input wd_byte_t d);
        @(negedge mclk);
        fb_addr = a;
        fb_wdata = d;
        fb_wr = wr;
        fb_rd = !wr;
        @(negedge mclk);
        fb_wr = 1'b0;
        fb_rd = 1'b0;
        fb_addr = ~a;
        fb_wdata = ~d;
    endtask

    // One host byte access; the host carries no write data
    task automatic host_access(input wd_addr_t a, input logic wr);
        @(negedge mclk);
        host_addr = a;
        host_wr = wr;
        host_rd = !wr;
        @(negedge mclk);
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = ~a;
    endtask
endmodule
`default_nettype wire

// ==== bench/wdog_top_tb.sv ====
// Self-checking testbench of the watchdog block.
// Assumes wdog_bus_model makes all register accesses.
`timescale 1ns/1ps
`default_nettype none
module wdog_top_tb
    import wdog_pkg::*;
;
    logic       mclk;       // 20 MHz clock
    logic       rst;        // Synchronous reset
    logic       base_tick;  // Base tick, every other cycle
    wd_addr_t   fb_addr;    // Fieldbus address
    logic       fb_wr;      // Fieldbus write
    logic       fb_rd;      // Fieldbus read
    wd_byte_t   fb_wdata;   // Fieldbus data
    logic [7:0] fb_rdata;   // Fieldbus read data
    wd_addr_t   host_addr;  // Host address
    logic       host_wr;    // Host write
    logic       host_rd;    // Host read
    logic [7:0] host_rdata; // Host read data
    logic [3:0] buf_wr;     // Channel writes
    logic [3:0] buf_trig_en; // Channel trigger enables
    logic       link_wd;    // Host watchdog expired
    logic       app_event_pd; // Process event bit
    int         err_total;
    int         comparisons;
    int         cycles;
    int         n;

    // ============================================================
    // Clock, base tick and timeout
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;
    always @(negedge mclk) base_tick <= ~base_tick;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            end_sim();
        end
    end

    wdog_bus_model u_bus (.mclk(mclk), .fb_addr(fb_addr), .fb_wr(fb_wr), .fb_rd(fb_rd),
        .fb_wdata(fb_wdata), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd));

    wdog_top #(.NCH(4)) u_dut (.mclk(mclk), .rst(rst), .base_tick(base_tick),
        .fb_addr(fb_addr), .fb_wr(fb_wr), .fb_rd(fb_rd), .fb_wdata(fb_wdata),
        .fb_rdata(fb_rdata), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_rdata(host_rdata), .buf_wr(buf_wr), .buf_trig_en(buf_trig_en),
        .link_status_host_wd(link_wd), .app_event_pd(app_event_pd));

    // ============================================================
    // Checking tasks
    task automatic chk(input string s, input wd_addr_t a, input wd_byte_t e, input wd_byte_t g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %s at %h expected %h seen %h", s, a, e, g);
        end
    endtask

    // Fieldbus read and compare, one cycle after the strobes are released
    task automatic fb_chk(input wd_addr_t a, input wd_byte_t e);
        u_bus.fb_access(a, 1'b0, 8'h00);
        @(negedge mclk);
        chk("fb_rdata", a, e, fb_rdata);
    endtask

    // Bounded wait for a flag; sel 0 is host expiry, 1 the event bit
    task automatic wait_bit(input int sel, input logic v);
        int i;
        for (i = 0; i < 700; i++) begin
            if (((sel == 0) ? link_wd : app_event_pd) === v) break;
            @(negedge mclk);
        end
        chk(sel ? "app_event_pd" : "link_status", 12'h000, {7'b0, v},
            {7'b0, (sel == 0) ? link_wd : app_event_pd});
    endtask

    // One channel write pulse with a chosen trigger enable
    task automatic pulse_buf(input int ch, input logic en);
        @(negedge mclk);
        buf_trig_en = en ? 4'hf : 4'h0;
        buf_wr[ch] = 1'b1;
        @(negedge mclk);
        buf_wr = 4'h0;
    endtask

    task automatic end_sim();
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ============================================================
    // Test sequence
    initial begin
        rst = 1'b1;
        base_tick = 1'b0;
        buf_wr = 4'h0;
        buf_trig_en = 4'h0;
        err_total = 0;
        comparisons = 0;
        cycles = 0;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        // Reset values, low byte first
        fb_chk(12'h400, 8'hc2);
        fb_chk(12'h401, 8'h09);
        fb_chk(12'h410, 8'he8);
        fb_chk(12'h411, 8'h03);
        fb_chk(12'h420, 8'he8);
        fb_chk(12'h421, 8'h03);
        fb_chk(12'h442, 8'h00);
        fb_chk(12'h443, 8'h00);
        fb_chk(12'h7ff, 8'h00);
        u_bus.host_access(12'h410, 1'b0);
        @(negedge mclk);
        chk("host_rdata", 12'h410, 8'he8, host_rdata);
        // Host writes leave the time register alone
        u_bus.host_access(12'h410, 1'b1);
        fb_chk(12'h410, 8'he8);
        // Shortest increment, short periods
        u_bus.fb_access(12'h400, 1'b1, 8'h00);
        u_bus.fb_access(12'h401, 1'b1, 8'h00);
        u_bus.fb_access(12'h420, 1'b1, 8'h40);
        u_bus.fb_access(12'h421, 1'b1, 8'h00);
        u_bus.fb_access(12'h410, 1'b1, 8'h03);
        u_bus.fb_access(12'h411, 1'b1, 8'h00);
        fb_chk(12'h410, 8'h03);
        fb_chk(12'h411, 8'h00);
        // Process watchdog expiry, status and event clear
        wait_bit(1, 1'b1);
        fb_chk(12'h440, 8'h00);
        fb_chk(12'h441, 8'h00);
        chk("app_event_pd", 12'h440, 8'h00, {7'b0, app_event_pd});
        fb_chk(12'h442, 8'h01);
        // Only trigger-enabled channel writes restart it
        pulse_buf(1, 1'b0);
        fb_chk(12'h440, 8'h00);
        pulse_buf(2, 1'b1);
        fb_chk(12'h440, 8'h01);
        // Host access restarts host watchdog, which then expires
        u_bus.host_access(12'h7ff, 1'b0);
        repeat (6) @(negedge mclk);
        chk("link_status", 12'h000, 8'h00, {7'b0, link_wd});
        wait_bit(0, 1'b1);
        // Host cannot clear counters; a fieldbus write clears both
        u_bus.host_access(12'h442, 1'b1);
        fb_chk(12'h442, 8'h01);
        u_bus.fb_access(12'h443, 1'b1, 8'h55);
        fb_chk(12'h443, 8'h00);
        fb_chk(12'h442, 8'h00);
        // Both expiry counters saturate
        u_bus.fb_access(12'h410, 1'b1, 8'h01);
        u_bus.fb_access(12'h420, 1'b1, 8'h01);
        for (n = 0; n < 260; n++) begin
            pulse_buf(0, 1'b1);
            u_bus.host_access(12'h000, 1'b0);
            wait_bit(0, 1'b0);
            wait_bit(0, 1'b1);
            wait_bit(1, 1'b1);
            fb_chk(12'h440, 8'h00);
        end
        fb_chk(12'h442, 8'hff);
        fb_chk(12'h443, 8'hff);
        // Zero period disables the host watchdog
        u_bus.fb_access(12'h410, 1'b1, 8'h00);
        u_bus.host_access(12'h000, 1'b0);
        repeat (40) @(negedge mclk);
        chk("link_status", 12'h000, 8'h00, {7'b0, link_wd});
        end_sim();
    end
endmodule
`default_nettype wire
